// *** design/wdt_defines.vh ***
// What this block does
// - Counter advances on each rising edge of the 2 Hz clock-timer tick.
// - Unrestarted for 3.5 to 4 seconds, the CPU initial reset is issued.
// - Three-stage binary counter; overflow of top stage raises initial reset.
// - Counting continues while the CPU is halted.
// - Build option removes the watchdog; then no reset is ever issued.
// - Writing one to bit 3 clears the counter; writing zero does nothing.
// - Restart bit is write-only and reads as zero.
// - Bits 2..0 read counter stages 1/4, 1/2, 1 Hz; zero after reset.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define WDT_ADDR_W 10
`define WDT_REG_CTRL_CNT 10'h2ef
`define WDT_DATA_W 4
`define WDT_BIT_RESTART 3
`define WDT_CNT_W 3
`define WDT_CNT_RESET 3'h0
`define WDT_RD_ZERO 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_RESET_PULSE_NS 100
`define WDT_CLK_PERIOD_NS 25
`define WDT_RESET_PULSE_CYC ((`WDT_RESET_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`define WDT_PULSE_CNT_W 3

`endif

// *** design/wdt_sync2.v ***
module wdt_sync2 (
    input wire clk,
    input wire arst_n,
    input wire din,
    output reg dout
);

    reg meta_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

// *** design/wdt_counter.v ***
`include "wdt_defines.vh"

module wdt_counter (
    input wire clk,
    input wire arst_n,
    input wire tick,
    input wire clear,
    output reg [`WDT_CNT_W-1:0] count_q,
    output wire overflow
);

    // ----------------------------------------
    // Three-stage counter
    // ----------------------------------------
    assign overflow = tick && !clear && (count_q == {`WDT_CNT_W{1'b1}});

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= `WDT_CNT_RESET;
        end else if (clear) begin
            count_q <= `WDT_CNT_RESET;
        end else if (tick) begin
            count_q <= count_q + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// *** design/wdt_top.v ***
`include "wdt_defines.vh"

module wdt_top #(
    parameter WDT_PRESENT = 1
) (
    input wire clk,
    input wire arst_n,
    input wire tick_2hz,
    input wire cpu_halted,
    input wire [`WDT_ADDR_W-1:0] reg_addr,
    input wire [`WDT_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`WDT_DATA_W-1:0] reg_rdata,
    output reg wdog_reset_out
);

    // ----------------------------------------
    // Tick synchroniser and edge detect
    // ----------------------------------------
    wire tick_s;
    reg tick_prev_q;
    wire tick_rise;
    wire [`WDT_CNT_W-1:0] count;
    wire overflow;
    wire restart_wr;
    wire wdog_clear;
    reg [`WDT_PULSE_CNT_W-1:0] pulse_q;
    reg [`WDT_DATA_W-1:0] rdata_d;
    wire [31:0] pulse_load_w;

    // Address decode shared by the write and read paths
    function reg_hit;
        input [`WDT_ADDR_W-1:0] addr;
        begin
            reg_hit = (addr == `WDT_REG_CTRL_CNT);
        end
    endfunction

    // Pulse length in cycles, narrowed on purpose to the pulse counter
    assign pulse_load_w = `WDT_RESET_PULSE_CYC;

    wdt_sync2 u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(tick_2hz),
        .dout(tick_s)
    );

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= tick_s;
        end
    end

    // Halt does not gate the tick
    assign tick_rise = tick_s && !tick_prev_q;

    // ----------------------------------------
    // Restart decode
    // ----------------------------------------
    assign restart_wr = reg_wr && reg_hit(reg_addr)
                        && reg_wdata[`WDT_BIT_RESTART];
    assign wdog_clear = restart_wr || (pulse_q != {`WDT_PULSE_CNT_W{1'b0}});

    wdt_counter u_cnt (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick_rise),
        .clear(wdog_clear),
        .count_q(count),
        .overflow(overflow)
    );

    // ----------------------------------------
    // Reset pulse generation
    // ----------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_q <= {`WDT_PULSE_CNT_W{1'b0}};
            wdog_reset_out <= 1'b0;
        end else begin
            if ((WDT_PRESENT != 0) && overflow) begin
                pulse_q <= pulse_load_w[`WDT_PULSE_CNT_W-1:0];
            end else if (pulse_q != {`WDT_PULSE_CNT_W{1'b0}}) begin
                pulse_q <= pulse_q - {{(`WDT_PULSE_CNT_W-1){1'b0}}, 1'b1};
            end
            wdog_reset_out <= (WDT_PRESENT != 0) && (overflow ||
                              (pulse_q > {{(`WDT_PULSE_CNT_W-1){1'b0}}, 1'b1}));
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always @* begin
        rdata_d = `WDT_RD_ZERO;
        if (reg_rd && reg_hit(reg_addr)) begin
            rdata_d = {1'b0, count};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `WDT_RD_ZERO;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

// *** verification/wdt_top_sva.sv ***
module wdt_chk #(parameter WDT_PRESENT = 1) (
    input wire clk,
    input wire arst_n,
    input wire tick_2hz,
    input wire cpu_halted,
    input wire [9:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_rdata,
    input wire wdog_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire m = reg_addr == 10'h2ef;
    wire um = reg_rd && !m;
    wire rdm = reg_rd && m;
    sequence clr; reg_wr && m && reg_wdata[3]; endsequence
    AST_IDLE: assert property (!$past(reg_rd) |-> !reg_rdata) else $error("stale");
    AST_RBIT: assert property (reg_rd |=> !reg_rdata[3]) else $error("bit3");
    AST_UNMAP: assert property (um |=> !reg_rdata) else $error("unmap");
    AST_CLR: assert property (clr ##1 rdm |=> !reg_rdata) else $error("clr");
    AST_PULSE: assert property ($rose(wdog_reset_out) |-> wdog_reset_out[*4] ##1 !wdog_reset_out)
        else $error("pulse");
    AST_TICK: assert property ($rose(wdog_reset_out) |-> $past(tick_2hz, 2)) else $error("tick");
    AST_ZERO: assert property ($fell(wdog_reset_out) ##1 rdm |=> !reg_rdata) else $error("zero");
    AST_OFF: assert property (WDT_PRESENT == 0 |-> !wdog_reset_out) else $error("off");
endmodule
bind wdt_top wdt_chk #(.WDT_PRESENT(WDT_PRESENT)) u_chk (.*);

// *** verification/wdt_cpu.sv ***
module wdt_cpu (
    input wire cpu_rst,
    output int pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counts initial reset pulses taken by the CPU
    initial pulses = 0;
    always @(posedge cpu_rst) pulses <= pulses + 1;
endmodule

// *** verification/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, tick_2hz = 0, cpu_halted = 0, reg_wr = 0, reg_rd = 0;
    logic [9:0] reg_addr = 10'h2ef;
    logic [3:0] reg_wdata = 4'h0, reg_rdata;
    wire wdog_reset_out, rst_off;
    int mismatches = 0, checks = 0, pulses, off_hits = 0;
    // Counts cycles in which the build without watchdog raises its reset
    always @(posedge clk) if (rst_off === 1'b1) off_hits <= off_hits + 1;
    wdt_top i_wdt_top (.*);
    wdt_top #(.WDT_PRESENT(0)) i_wdt_top_off (.*, .reg_rdata(), .wdog_reset_out(rst_off));
    wdt_cpu i_wdt_cpu (.cpu_rst(wdog_reset_out), .pulses(pulses));
    initial forever #12.5 clk = ~clk;
    task finish_test;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask
    task acc(input [9:0] a, input [3:0] d, input w, input r);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, r};
    endtask
    task rd(input [9:0] a, input [3:0] e);
        acc(a, 4'h0, 0, 1);
        acc(a, 4'h0, 0, 0);
        #1 chk(reg_rdata, e);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge clk) tick_2hz <= 1;
            repeat (6) @(posedge clk);
            tick_2hz <= 0;
            repeat (6) @(posedge clk);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1;
        rd(10'h2ef, 4'h0);
        tick(3);
        rd(10'h2ef, 4'h3);
        acc(10'h2ef, 4'h7, 1, 0);
        acc(10'h2ee, 4'h8, 1, 0);
        rd(10'h2ef, 4'h3);
        rd(10'h2ee, 4'h0);
        acc(10'h2ef, 4'hf, 1, 0);
        rd(10'h2ef, 4'h0);
        cpu_halted <= 1;
        tick(7);
        @(posedge clk) tick_2hz <= 1;
        @(negedge wdog_reset_out);
        rd(10'h2ef, 4'h0);
        chk(pulses, 1);
        chk(off_hits, 0);
        finish_test;
    end
    initial begin
        #20us;
        mismatches++;
        finish_test;
    end
endmodule
